// *** src/hot_swap_pkg.sv ***
package hot_swap_pkg;

   // Timing: core clock is 20 MHz
   localparam int CLK_PERIOD_NS = 50;
   localparam int ENABLE_FILTER_US = 3;
   localparam int ENABLE_FILTER_CYCLES =
      (ENABLE_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Analog figures kept for reference in mV and uA
   localparam int SUPPLY_RISE_MV = 2800;
   localparam int SUPPLY_HYST_MV = 80;
   localparam int DELAY_LOWER_MV = 200;
   localparam int DELAY_UPPER_MV = 1300;
   localparam int GATE_PULLUP_UA = 12;
   localparam int GATE_PULLDOWN_UA = 2000;

   // Reset value of the variant straps
   localparam bit ENABLE_LOW_DEFAULT = 1'b0;
   localparam bit AUTO_RETRY_DEFAULT = 1'b1;

   // Delay capacitor current source selection
   typedef enum logic [2:0] {
      SRC_PULLUP_5UA,
      SRC_PULLUP_60UA,
      SRC_PULLDOWN_2UA,
      SRC_PULLDOWN_100UA
   } delay_source_type;

   // Gate drive mode
   typedef enum logic [2:0] {
      GATE_HOLD_LOW,
      GATE_PULL_UP,
      GATE_REGULATE,
      GATE_FULL_ON,
      GATE_STRONG_DOWN
   } gate_mode_type;

   // Comparator outputs from the analog front end
   typedef struct packed {
      logic supply_ok;
      logic enable_cmp;
      logic delay_below_lower;
      logic delay_above_upper;
      logic over_fault_timing;
      logic fast_trip;
   } comparator_type;

   // One-hot enables for the delay capacitor sources
   typedef struct packed {
      logic pullup_5ua;
      logic pullup_60ua;
      logic pulldown_2ua;
      logic pulldown_100ua;
   } delay_drive_type;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_INIT_CHARGE,
      ST_INIT_DISCHARGE,
      ST_IDLE,
      ST_RAMP,
      ST_ON,
      ST_FAULT_LATCHED,
      ST_COOL_DOWN
   } seq_state_type;

endpackage

// *** src/sync_filter.sv ***
`timescale 1ns/1ns
// Two-flop synchroniser followed by a stability filter
module sync_filter #(
   parameter int FILTER_CYCLES = 60,
   parameter bit RESET_VALUE = 1'b0
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Raw input and filtered output
   input wire logic raw_in,
   output logic filt_out
);
   localparam int CW = $clog2(FILTER_CYCLES + 1);

   initial begin
      if (FILTER_CYCLES < 1) begin
         $error("sync_filter: FILTER_CYCLES must be at least one");
      end
   end

   logic meta_ff;
   logic sync_ff;
   logic [CW-1:0] count_ff;
   logic filt_ff;

   // Two flops ahead of any logic
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meta_ff <= RESET_VALUE;
         sync_ff <= RESET_VALUE;
      end else begin
         meta_ff <= raw_in;
         sync_ff <= meta_ff;
      end
   end

   // Accept a change only after it stands for the full window
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         count_ff <= '0;
         filt_ff <= RESET_VALUE;
      end else if (sync_ff == filt_ff) begin
         count_ff <= '0;
      end else if (count_ff == CW'(FILTER_CYCLES - 1)) begin
         count_ff <= '0;
         filt_ff <= sync_ff;
      end else begin
         count_ff <= count_ff + CW'(1);
      end
   end

   assign filt_out = filt_ff;
endmodule

// *** src/delay_source_decode.sv ***
`timescale 1ns/1ns
// One-hot decode of the delay capacitor source selection
module delay_source_decode (
   // Selected source
   input wire hot_swap_pkg::delay_source_type sel,
   // One-hot enables
   output hot_swap_pkg::delay_drive_type drive
);
   import hot_swap_pkg::*;

   // Exactly one enable per selection, pull-down on any unused code
   always_comb begin
      drive = '0;
      unique case (sel)
         SRC_PULLUP_5UA: drive.pullup_5ua = 1'b1;
         SRC_PULLUP_60UA: drive.pullup_60ua = 1'b1;
         SRC_PULLDOWN_2UA: drive.pulldown_2ua = 1'b1;
         SRC_PULLDOWN_100UA: drive.pulldown_100ua = 1'b1;
         default: drive.pulldown_100ua = 1'b1;
      endcase
   end
endmodule

// *** src/hot_swap_sequencer.sv ***
`timescale 1ns/1ns
module hot_swap_sequencer #(
   parameter int FILTER_CYCLES = hot_swap_pkg::ENABLE_FILTER_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Analog comparator outputs, asynchronous to the clock
   input wire hot_swap_pkg::comparator_type cmp,
   // Variant straps
   input wire logic enable_low_input,
   input wire logic auto_retry,
   // Gate drive and delay capacitor sources
   output hot_swap_pkg::gate_mode_type gate_mode,
   output hot_swap_pkg::delay_drive_type delay_drive,
   // Status
   output hot_swap_pkg::seq_state_type seq_state,
   output logic fault_flag,
   output logic in_reset
);
   import hot_swap_pkg::*;

   initial begin
      if (FILTER_CYCLES < 1) begin
         $error("hot_swap_sequencer: FILTER_CYCLES must be at least one");
      end
   end

   // Synchronised comparator levels
   logic [3:0] meta_ff;
   logic [3:0] sync_ff;
   logic supply_ok_meta_ff;
   logic supply_ok_ff;
   logic enable_filt;
   logic enable_low_ff;
   logic auto_retry_ff;
   logic enable_on;
   logic enable_on_prev_ff;
   logic enable_rise;
   logic below_lower;
   logic above_upper;
   logic over_timing;
   logic fast_trip;

   seq_state_type state_ff;
   seq_state_type nxt_state;
   delay_source_type nxt_source;
   delay_source_type source_ff;
   gate_mode_type nxt_gate;
   gate_mode_type gate_ff;

   // Supply lockout level, synchronised; low holds the state, drive and enable edge registers in reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         supply_ok_meta_ff <= 1'b0;
         supply_ok_ff <= 1'b0;
      end else begin
         supply_ok_meta_ff <= cmp.supply_ok;
         supply_ok_ff <= supply_ok_meta_ff;
      end
   end

   // Two flops ahead of the other comparator levels
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= {cmp.delay_below_lower, cmp.delay_above_upper,
                     cmp.over_fault_timing, cmp.fast_trip};
         sync_ff <= meta_ff;
      end
   end

   assign below_lower = sync_ff[3];
   assign above_upper = sync_ff[2];
   assign over_timing = sync_ff[1];
   assign fast_trip = sync_ff[0];

   // Enable comparator filtered before any action
   sync_filter #(
      .FILTER_CYCLES(FILTER_CYCLES),
      .RESET_VALUE(1'b0)
   ) u_enable_filter (
      .core_clk(core_clk),
      .rstn(rstn),
      .raw_in(cmp.enable_cmp),
      .filt_out(enable_filt)
   );

   // Straps caught by a clocked process while supply is low
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         enable_low_ff <= ENABLE_LOW_DEFAULT;
         auto_retry_ff <= AUTO_RETRY_DEFAULT;
      end else if (!supply_ok_ff) begin
         enable_low_ff <= enable_low_input;
         auto_retry_ff <= auto_retry;
      end
   end

   // Polarity applied after filtering
   assign enable_on = enable_filt ^ enable_low_ff;

   // Previous enable level for edge detection
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         enable_on_prev_ff <= 1'b0;
      end else if (!supply_ok_ff) begin
         enable_on_prev_ff <= 1'b0;
      end else begin
         enable_on_prev_ff <= enable_on;
      end
   end

   assign enable_rise = enable_on && !enable_on_prev_ff;

   // Next state and outputs of the sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_source = SRC_PULLDOWN_100UA;
      nxt_gate = GATE_HOLD_LOW;
      unique case (state_ff)
         ST_INIT_CHARGE: begin
            nxt_source = SRC_PULLUP_5UA;
            if (above_upper) begin
               nxt_state = ST_INIT_DISCHARGE;
               nxt_source = SRC_PULLDOWN_100UA;
            end
         end
         ST_INIT_DISCHARGE: begin
            nxt_source = SRC_PULLDOWN_100UA;
            if (below_lower) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            // Level start covers enable already asserted at power-up
            if (enable_on) begin
               nxt_state = ST_RAMP;
               nxt_gate = GATE_PULL_UP;
            end
         end
         ST_RAMP: begin
            if (!enable_on) begin
               nxt_state = ST_IDLE;
            end else if (over_timing && above_upper) begin
               nxt_state = auto_retry_ff ? ST_COOL_DOWN : ST_FAULT_LATCHED;
               nxt_gate = GATE_STRONG_DOWN;
               nxt_source = auto_retry_ff ? SRC_PULLDOWN_2UA : SRC_PULLDOWN_100UA;
            end else if (fast_trip) begin
               nxt_gate = GATE_STRONG_DOWN;
               nxt_source = over_timing ? SRC_PULLUP_60UA : SRC_PULLDOWN_100UA;
            end else if (over_timing) begin
               nxt_gate = GATE_REGULATE;
               nxt_source = SRC_PULLUP_60UA;
            end else begin
               nxt_gate = GATE_PULL_UP;
               if (below_lower) begin
                  nxt_state = ST_ON;
                  nxt_gate = GATE_FULL_ON;
               end
            end
         end
         ST_ON: begin
            nxt_gate = GATE_FULL_ON;
            nxt_source = SRC_PULLDOWN_100UA;
            if (!enable_on) begin
               nxt_state = ST_IDLE;
               nxt_gate = GATE_HOLD_LOW;
            end else if (fast_trip) begin
               nxt_state = ST_RAMP;
               nxt_gate = GATE_STRONG_DOWN;
            end else if (over_timing) begin
               nxt_state = ST_RAMP;
               nxt_gate = GATE_REGULATE;
               nxt_source = SRC_PULLUP_60UA;
            end
         end
         ST_FAULT_LATCHED: begin
            nxt_gate = GATE_STRONG_DOWN;
            if (!enable_on) begin
               nxt_state = ST_IDLE;
               nxt_gate = GATE_HOLD_LOW;
            end
         end
         ST_COOL_DOWN: begin
            nxt_gate = GATE_STRONG_DOWN;
            nxt_source = SRC_PULLDOWN_2UA;
            if (!enable_on) begin
               nxt_state = ST_IDLE;
               nxt_gate = GATE_HOLD_LOW;
               nxt_source = SRC_PULLDOWN_100UA;
            end else if (below_lower) begin
               nxt_state = ST_RAMP;
               nxt_gate = GATE_PULL_UP;
               nxt_source = SRC_PULLDOWN_100UA;
            end
         end
         default: begin
            nxt_state = ST_INIT_CHARGE;
         end
      endcase
   end

   // Sequencer state register; low supply restarts the initial cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_INIT_CHARGE;
      end else if (!supply_ok_ff) begin
         state_ff <= ST_INIT_CHARGE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Drive registers, held low and pulled down while in reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         gate_ff <= GATE_HOLD_LOW;
         source_ff <= SRC_PULLDOWN_100UA;
      end else if (!supply_ok_ff) begin
         gate_ff <= GATE_HOLD_LOW;
         source_ff <= SRC_PULLDOWN_100UA;
      end else begin
         gate_ff <= nxt_gate;
         source_ff <= nxt_source;
      end
   end

   // One-hot source enables
   delay_source_decode u_decode (
      .sel(source_ff),
      .drive(delay_drive)
   );

   assign gate_mode = gate_ff;
   assign seq_state = state_ff;
   assign fault_flag = (state_ff == ST_FAULT_LATCHED) || (state_ff == ST_COOL_DOWN);
   assign in_reset = !supply_ok_ff;

   // Low supply forces the gate low one cycle later
   property p_reset_gate_low;
      @(posedge core_clk) disable iff (!rstn)
         !supply_ok_ff |=> gate_ff == GATE_HOLD_LOW;
   endproperty
   a_reset_gate_low: assert property (p_reset_gate_low) else $error("gate not low in reset");

   // No gate drive before the initial cycle completes
   property p_no_drive_early;
      @(posedge core_clk) disable iff (!rstn)
         (state_ff == ST_INIT_CHARGE || state_ff == ST_INIT_DISCHARGE)
            |-> gate_ff == GATE_HOLD_LOW;
   endproperty
   a_no_drive_early: assert property (p_no_drive_early) else $error("gate driven early");

   // A rising filtered enable in idle starts the ramp with the gate pull-up
   property p_enable_start;
      @(posedge core_clk) disable iff (!rstn)
         supply_ok_ff && state_ff == ST_IDLE && enable_rise
            |=> state_ff == ST_RAMP && gate_ff == GATE_PULL_UP;
   endproperty
   a_enable_start: assert property (p_enable_start) else $error("enable start missed");

   // Initial charge uses the small pull-up
   property p_init_charge;
      @(posedge core_clk) disable iff (!rstn)
         supply_ok_ff && state_ff == ST_INIT_CHARGE && !above_upper
            |=> source_ff == SRC_PULLUP_5UA;
   endproperty
   a_init_charge: assert property (p_init_charge) else $error("init charge source wrong");

   // Enable dropped during operation grounds the gate
   property p_enable_abort;
      @(posedge core_clk) disable iff (!rstn)
         supply_ok_ff && !enable_on && (state_ff == ST_ON || state_ff == ST_RAMP)
            |=> gate_ff == GATE_HOLD_LOW && source_ff == SRC_PULLDOWN_100UA;
   endproperty
   a_enable_abort: assert property (p_enable_abort) else $error("enable abort missed");

   // Overcurrent in ramp times the fault on the 60 uA source
   property p_fault_timing;
      @(posedge core_clk) disable iff (!rstn)
         supply_ok_ff && state_ff == ST_RAMP && enable_on && over_timing && !above_upper
            |=> source_ff == SRC_PULLUP_60UA;
   endproperty
   a_fault_timing: assert property (p_fault_timing) else $error("fault timing source off");

   // Fast trip pulls the gate down on the next edge
   property p_fast_trip;
      @(posedge core_clk) disable iff (!rstn)
         supply_ok_ff && enable_on && fast_trip
            && (state_ff == ST_RAMP || state_ff == ST_ON)
            |=> gate_ff == GATE_STRONG_DOWN;
   endproperty
   a_fast_trip: assert property (p_fast_trip) else $error("fast trip not acted on");

   // Expired fault time leads to a fault state
   property p_fault_declared;
      @(posedge core_clk) disable iff (!rstn)
         supply_ok_ff && state_ff == ST_RAMP && enable_on && over_timing && above_upper
            |=> fault_flag && gate_ff == GATE_STRONG_DOWN;
   endproperty
   a_fault_declared: assert property (p_fault_declared) else $error("fault not declared");

   // Latched fault holds while enable stays asserted
   property p_latch_hold;
      @(posedge core_clk) disable iff (!rstn)
         supply_ok_ff && state_ff == ST_FAULT_LATCHED && enable_on
            |=> state_ff == ST_FAULT_LATCHED;
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch-off released");

   // Cool-down ends in a retry at the lower threshold
   property p_retry;
      @(posedge core_clk) disable iff (!rstn)
         supply_ok_ff && state_ff == ST_COOL_DOWN && enable_on && below_lower
            |=> state_ff == ST_RAMP ##0 gate_ff == GATE_PULL_UP;
   endproperty
   a_retry: assert property (p_retry) else $error("auto retry missing");

   // Never more than one delay source enabled
   property p_one_source;
      @(posedge core_clk) disable iff (!rstn)
         $onehot(delay_drive);
   endproperty
   a_one_source: assert property (p_one_source) else $error("delay sources not one-hot");
endmodule

// *** verif/delay_cap_model.sv ***
`timescale 1ns/1ns
// Timing capacitor on the delay node and its two threshold comparators
module delay_cap_model (
   // Clock
   input wire logic core_clk,
   // Current source enables from the sequencer
   input wire hot_swap_pkg::delay_drive_type delay_drive,
   // Comparator outputs
   output logic delay_below_lower,
   output logic delay_above_upper
);
   import hot_swap_pkg::*;

   // Node level in scaled units: 200 is the lower threshold, 1300 the upper one
   int level = 0;
   int step;

   // Net charge per cycle follows the source sizes, so the timing ratios hold
   always_comb begin
      step = 5 * int'(delay_drive.pullup_5ua) + 60 * int'(delay_drive.pullup_60ua)
         - 2 * int'(delay_drive.pulldown_2ua) - 100 * int'(delay_drive.pulldown_100ua);
   end

   // Integrate the node, clamped between ground and the supply
   always @(posedge core_clk) begin
      level <= (level + step < 0) ? 0 : ((level + step > 1600) ? 1600 : level + step);
   end

   // Threshold comparators seen by the sequencer
   assign delay_below_lower = (level <= 200);
   assign delay_above_upper = (level >= 1300);
endmodule

// *** verif/hot_swap_sequencer_test.sv ***
`timescale 1ns/1ns
// Self-checking bench for the hot swap sequencer
module hot_swap_sequencer_test;
   import hot_swap_pkg::*;

   localparam int FILT = 4;
   logic core_clk, rstn, supply_ok, enable_cmp, over_fault_timing, fast_trip;
   logic enable_low_input, auto_retry, below_lower, above_upper, fault_flag, in_reset;
   comparator_type cmp;
   gate_mode_type gate_mode;
   delay_drive_type delay_drive;
   seq_state_type seq_state;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   bit en_low;
   bit retry_mode;

   // Comparator bundle, delay bits come from the capacitor model
   assign cmp = {supply_ok, enable_cmp, below_lower, above_upper, over_fault_timing, fast_trip};

   hot_swap_sequencer #(.FILTER_CYCLES(FILT)) dut (.core_clk(core_clk), .rstn(rstn),
      .cmp(cmp), .enable_low_input(enable_low_input), .auto_retry(auto_retry),
      .gate_mode(gate_mode), .delay_drive(delay_drive), .seq_state(seq_state),
      .fault_flag(fault_flag), .in_reset(in_reset));

   delay_cap_model partner (.core_clk(core_clk), .delay_drive(delay_drive),
      .delay_below_lower(below_lower), .delay_above_upper(above_upper));

   // Clock generation
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Prints the totals and the verdict, then stops
   task automatic conclude();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Exactly one delay source is on in every cycle out of reset
   always @(negedge core_clk) begin
      if (rstn === 1'b1) begin
         check(8'($countones(delay_drive)), 8'h01);
      end
   end

   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // Waits a bounded time for a state, then compares
   task automatic wait_state(input seq_state_type s, input int limit);
      int n;
      n = 0;
      while (seq_state !== s && n < limit) begin
         @(negedge core_clk);
         n++;
      end
      check(8'(seq_state), 8'(s));
   endtask

   // Drives the enable pin in the variant's polarity
   task automatic set_enable(input bit on);
      @(posedge core_clk);
      enable_cmp <= on ^ en_low;
   endtask

   // Supply drop with new straps, then a full initial timing cycle
   task automatic power_up(input bit low, input bit retry);
      @(posedge core_clk);
      supply_ok <= 1'b0;
      enable_low_input <= low;
      auto_retry <= retry;
      enable_cmp <= low;
      over_fault_timing <= 1'b0;
      fast_trip <= 1'b0;
      en_low = low;
      retry_mode = retry;
      idle(6);
      check(8'(in_reset), 8'h01);
      check(8'(gate_mode), 8'(GATE_HOLD_LOW));
      check(8'(delay_drive), 8'h01);
      @(posedge core_clk);
      supply_ok <= 1'b1;
      idle(5);
      check(8'(in_reset), 8'h00);
      check(8'(delay_drive), 8'h08);
      wait_state(ST_INIT_DISCHARGE, 400);
      check(8'(delay_drive), 8'h01);
      check(8'(gate_mode), 8'(GATE_HOLD_LOW));
      wait_state(ST_IDLE, 100);
      idle(20);
      check(8'(seq_state), 8'(ST_IDLE));
      check(8'(gate_mode), 8'(GATE_HOLD_LOW));
   endtask

   // Short enable glitch is ignored, a clean assertion starts the ramp
   task automatic start_ramp();
      set_enable(1'b1);
      set_enable(1'b0);
      idle(12);
      check(8'(seq_state), 8'(ST_IDLE));
      set_enable(1'b1);
      wait_state(ST_RAMP, FILT + 10);
      check(8'(gate_mode), 8'(GATE_PULL_UP));
   endtask

   // Current limit timed briefly, then falls off before the fault time
   task automatic normal_on();
      start_ramp();
      @(posedge core_clk);
      over_fault_timing <= 1'b1;
      idle(5);
      check(8'(gate_mode), 8'(GATE_REGULATE));
      check(8'(delay_drive), 8'h04);
      @(posedge core_clk);
      over_fault_timing <= 1'b0;
      wait_state(ST_ON, 20);
      check(8'(gate_mode), 8'(GATE_FULL_ON));
      check(8'(delay_drive), 8'h01);
   endtask

   // Fast trip while fully on, released before the fault time runs out
   task automatic fast_trip_run();
      @(posedge core_clk);
      fast_trip <= 1'b1;
      over_fault_timing <= 1'b1;
      // Gate acts one edge before the 60 uA source: ON leaves through RAMP first
      idle(5);
      check(8'(gate_mode), 8'(GATE_STRONG_DOWN));
      check(8'(delay_drive), 8'h04);
      @(posedge core_clk);
      fast_trip <= 1'b0;
      idle(4);
      check(8'(gate_mode), 8'(GATE_REGULATE));
      @(posedge core_clk);
      over_fault_timing <= 1'b0;
      wait_state(ST_ON, 30);
   endtask

   // Glitch on the enable keeps the load on, a real drop aborts
   task automatic abort_run();
      set_enable(1'b0);
      set_enable(1'b1);
      idle(12);
      check(8'(seq_state), 8'(ST_ON));
      set_enable(1'b0);
      wait_state(ST_IDLE, FILT + 10);
      check(8'(gate_mode), 8'(GATE_HOLD_LOW));
      check(8'(delay_drive), 8'h01);
   endtask

   // Overcurrent outlasts the fault time, then latch-off or cool-down
   task automatic fault_run();
      start_ramp();
      @(posedge core_clk);
      over_fault_timing <= 1'b1;
      wait_state(retry_mode ? ST_COOL_DOWN : ST_FAULT_LATCHED, 60);
      check(8'(gate_mode), 8'(GATE_STRONG_DOWN));
      check(8'(fault_flag), 8'h01);
      @(posedge core_clk);
      over_fault_timing <= 1'b0;
      if (retry_mode) begin
         check(8'(delay_drive), 8'h02);
         wait_state(ST_RAMP, 700);
         wait_state(ST_ON, 20);
      end else begin
         idle(700);
         check(8'(seq_state), 8'(ST_FAULT_LATCHED));
         check(8'(gate_mode), 8'(GATE_STRONG_DOWN));
         set_enable(1'b0);
         wait_state(ST_IDLE, FILT + 10);
         start_ramp();
      end
   endtask

   // Main sequence
   initial begin
      rstn = 1'b0;
      supply_ok = 1'b0;
      enable_cmp = 1'b0;
      over_fault_timing = 1'b0;
      fast_trip = 1'b0;
      enable_low_input = 1'b0;
      auto_retry = 1'b0;
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      power_up(1'b0, 1'b0);
      normal_on();
      fast_trip_run();
      abort_run();
      fault_run();
      power_up(1'b0, 1'b1);
      fault_run();
      power_up(1'b1, 1'b0);
      normal_on();
      abort_run();
      conclude();
   end
endmodule
